/* rtl/core_instruction_decode_timing.sv */
// Purpose: decode 14-bit words, set instruction cycle count, drive r-m-w
// Assumes: one word offered per instruction start; datapath reports flow
// Notes: the extra cycles are inserted as no-operation cycles
// Notes: a skip is judged in the last cycle of its instruction, so a skip
// that also pays for a slot access keeps both of its extra cycles
// Notes: pointer top bits and skip result are same-clock datapath levels
// How it works
// - each instruction is one 14-bit word with opcode and operands
// - opcodes sort into byte, bit, or literal-and-control classes
// - plain instructions finish in exactly one instruction cycle
// - both call forms take two instruction cycles
// - return, return-with-literal and interrupt exit take two cycles
// - jumps, branches and taken skips take two cycles
// - indirect access pointing at program memory adds one cycle
// - an instruction cycle is four oscillator cycles
// - file-register instructions other than bit tests read, modify, then store result
// - the file register is read even if only written
// - destination bit 0 writes accumulator, 1 writes file register
// - file address selects location 0x00 to 0x7f in the bank
// - bit select names one bit of an 8-bit register
// - pointer number picks pointer and slot pair 0 or 1
// - don't-care bits do not change the decode
// - two-bit mode picks pre/post increment/decrement
// - flow change or true test takes two cycles, second a no-op
// - slot access with pointer top bit set adds one cycle
// - bit ops lead with 01; next two bits select the operation
`timescale 1ns/1ns
`include "core_decode_regs.svh"

module core_instruction_decode_timing #(
    parameter int WORD_W = `WORD_W
) (
    input wire logic mclk, // oscillator clock
    input wire logic rst, // synchronous reset, high
    input wire logic [WORD_W-1:0] instr_word, // fetched instruction
    input wire logic skip_taken, // datapath: skip test true
    input wire logic pointer0_msb, // pointer 0 selects program memory
    input wire logic pointer1_msb, // pointer 1 selects program memory
    output core_decode_pkg::instr_class_t instr_class, // decoded class
    output logic [6:0] file_addr, // file address operand
    output logic [2:0] bit_sel, // bit position operand
    output logic [1:0] bit_op, // bit operation select
    output logic dest_file, // 1 writes file register, 0 accumulator
    output logic [7:0] literal, // 8-bit literal operand
    output logic pointer_num, // indirect pointer pair select
    output core_decode_pkg::pointer_update_mode_t pointer_update_mode, // mode
    output logic file_read, // read strobe for named register
    output logic file_write, // write strobe to file register
    output logic acc_write, // write strobe to accumulator
    output logic flow_change, // instruction changes program flow
    output logic [1:0] phase, // oscillator phase in instruction cycle
    output logic cycle_start, // one pulse per instruction cycle
    output logic instr_start, // current word is a new instruction
    output logic nop_cycle // current cycle executes as no-op
);
    import core_decode_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic names_file(input logic [WORD_W-1:0] w);
        logic [1:0] c;
        c = w[`CLASS_HI:`CLASS_LO];
        // control forms with zero upper byte carry no file operand
        names_file = (c == `CLASS_BIT) ||
            (c == `CLASS_BYTE && w[`WORD_W-1:`DEST_BIT] != 7'h00);
    endfunction

    function automatic logic touches_slot(input logic [6:0] a);
        touches_slot = (a == `SLOT0_ADDR) || (a == `SLOT1_ADDR);
    endfunction

    // byte-class skip forms: decrement or increment, skip when zero
    function automatic logic is_count_skip(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] m;
        m = w & `BYTE_OP_MASK;
        is_count_skip = (m == `OP_DECREMENT_SKIP_IF_ZERO) || (m == `OP_INCFSZ);
    endfunction

    // bit tests only read the register; the high op bit marks them
    function automatic logic is_bit_test(input logic [WORD_W-1:0] w);
        is_bit_test = (w[`CLASS_HI:`CLASS_LO] == `CLASS_BIT) &&
            w[`BITOP_HI];
    endfunction

    // absolute call or call through the accumulator
    function automatic logic is_call_form(input logic [WORD_W-1:0] w);
        is_call_form = (w[`CLASS_HI:`CLASS_LO] == `CLASS_JUMP &&
            !w[`JUMP_KIND_BIT]) || w == `OP_CALL_ACCUMULATOR_RELATIVE;
    endfunction

    // subroutine return, return with literal, interrupt exit
    function automatic logic is_return_form(input logic [WORD_W-1:0] w);
        is_return_form = w == `OP_RETURN || w == `OP_RETI ||
            (w & `RETLIT_MASK) == `OP_RETLIT;
    endfunction

    // absolute jump and both relative branches
    function automatic logic is_jump_form(input logic [WORD_W-1:0] w);
        is_jump_form = (w[`CLASS_HI:`CLASS_LO] == `CLASS_JUMP &&
            w[`JUMP_KIND_BIT]) || (w & `BRA_MASK) == `OP_BRA ||
            w == `OP_BRW;
    endfunction

    // indirect moves through a pointer and slot pair
    function automatic logic is_ind_form(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] m;
        m = w & `OP_MOVWI_MASK;
        is_ind_form = (m == `OP_MOVIW) || (m == `OP_MOVWI);
    endfunction

    // which pointer's top bit counts: the n field for indirect moves,
    // the low address bit for a direct slot access
    function automatic logic pointer_sel(input logic [WORD_W-1:0] w,
                                         input logic ind);
        pointer_sel = ind ? w[`PTR_NUM_BIT] : w[`FILE_ADDR_LO];
    endfunction

    // two top bits give the class; both upper codes are literal/control
    function automatic instr_class_t class_of(input logic [1:0] c);
        unique case (c)
            `CLASS_BYTE: class_of = cls_byte;
            `CLASS_BIT: class_of = cls_bit;
            default: class_of = cls_literal_control;
        endcase
    endfunction

    // store strobe is picked in the third phase and lands in the last phase of the first cycle only;
    // bit tests read but never store
    function automatic logic store_slot(input logic live, input logic test,
                                        input logic [1:0] ph);
        store_slot = live && !test && ph == `STORE_PHASE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // oscillator phase
    always_ff @(posedge mclk) begin
        if (rst)
            phase <= 2'd0;
        else
            phase <= phase + 2'd1;
    end

    assign cycle_start = (phase == 2'd0);

    ////////////////////////////////////////////////////////////////////////
    // combinational decode of the incoming word
    logic [1:0] w_class;
    logic is_call, is_return, is_jump, is_skip_op, is_slot, ptr_msb;
    logic is_rmw, is_ind;
    logic [1:0] next_extra;

    assign w_class = instr_word[`CLASS_HI:`CLASS_LO];
    always_comb begin
        is_call = is_call_form(instr_word);
        is_return = is_return_form(instr_word);
        is_jump = is_jump_form(instr_word);
        is_skip_op = is_count_skip(instr_word) ||
            is_bit_test(instr_word);
        is_ind = is_ind_form(instr_word);
        is_rmw = names_file(instr_word);
        // direct slot access, or indirect move forms
        is_slot = (is_rmw &&
            touches_slot(instr_word[`FILE_ADDR_HI:`FILE_ADDR_LO])) || is_ind;
        // the top bit of the chosen pointer says it aims at program memory
        ptr_msb = pointer_sel(instr_word, is_ind) ? pointer1_msb
            : pointer0_msb;
        next_extra = 2'd0;
        if (is_call || is_return || is_jump)
            next_extra = 2'd1;
        if (is_slot && ptr_msb)
            next_extra = next_extra + 2'd1;
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction sequencing
    logic [1:0] extra_left;
    logic cur_skip, pend_skip, skip_due;

    assign instr_start = cycle_start && extra_left == 2'd0 && !pend_skip;

    // skip result is only judged once no extra cycle is left, so the
    // datapath result of the final cycle is the one that counts
    assign skip_due = cur_skip && skip_taken && extra_left == 2'd0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            extra_left <= 2'd0;
            pend_skip <= 1'b0;
            cur_skip <= 1'b0;
        end else if (cycle_start) begin
            if (instr_start) begin
                extra_left <= next_extra;
                cur_skip <= is_skip_op;
            end else if (pend_skip) begin
                pend_skip <= 1'b0;
            end else begin
                extra_left <= extra_left - 2'd1;
            end
        end else if (phase == `PHASE_LAST) begin
            // a slot access that costs a cycle must not lose the skip
            if (skip_due)
                pend_skip <= 1'b1;
            if (extra_left == 2'd0)
                cur_skip <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // no-op marker
    // set one clock ahead of the cycle it marks, so it stands for all four
    // clocks of that cycle and is already low when the next word is taken
    always_ff @(posedge mclk) begin
        if (rst)
            nop_cycle <= 1'b0;
        else if (phase == `PHASE_LAST)
            nop_cycle <= extra_left != 2'd0 || skip_due;
    end

    ////////////////////////////////////////////////////////////////////////
    // operand fields, latched at instruction start
    always_ff @(posedge mclk) begin
        if (rst) begin
            instr_class <= cls_byte;
            file_addr <= 7'h00;
            bit_sel <= 3'd0;
            bit_op <= 2'd0;
            dest_file <= 1'b0;
            literal <= `ZERO_BYTE;
            pointer_num <= 1'b0;
            pointer_update_mode <= mode_pre_inc;
            flow_change <= 1'b0;
        end else if (instr_start) begin
            instr_class <= class_of(w_class);
            file_addr <= instr_word[`FILE_ADDR_HI:`FILE_ADDR_LO];
            bit_sel <= instr_word[`BIT_SEL_HI:`BIT_SEL_LO];
            bit_op <= instr_word[`BITOP_HI:`BITOP_LO];
            // bit ops write back to the file; byte ops follow d
            dest_file <= (w_class == `CLASS_BIT) ||
                instr_word[`DEST_BIT];
            literal <= instr_word[7:0];
            pointer_num <= instr_word[`PTR_NUM_BIT];
            pointer_update_mode <= pointer_update_mode_t'(
                instr_word[`MODE_HI:`MODE_LO]);
            flow_change <= is_call || is_return || is_jump;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read-modify-write strobes: read in second phase, store in last
    logic rmw_live, rmw_skip_bit;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rmw_live <= 1'b0;
            rmw_skip_bit <= 1'b0;
        end else if (instr_start) begin
            rmw_live <= is_rmw;
            // bit tests read only and never store
            rmw_skip_bit <= is_bit_test(instr_word);
        end else if (phase == `PHASE_LAST) begin
            rmw_live <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            file_read <= 1'b0;
            file_write <= 1'b0;
            acc_write <= 1'b0;
        end else begin
            // read even for write-only forms so read side effects occur
            file_read <= instr_start && is_rmw;
            file_write <= store_slot(rmw_live, rmw_skip_bit, phase) &&
                dest_file;
            acc_write <= store_slot(rmw_live, rmw_skip_bit, phase) &&
                !dest_file;
        end
    end
endmodule

/* rtl/core_decode_regs.svh */
// Purpose: named constants for the instruction decoder
// Assumes: 14-bit instruction words, four oscillator cycles per instruction cycle
// Notes: opcode patterns are compared after masking don't-care bits
`ifndef CORE_DECODE_REGS_SVH
`define CORE_DECODE_REGS_SVH

`define WORD_W 14
`define OSC_PER_CYCLE 3'd4
`define PHASE_LAST 2'd3
`define FILE_ADDR_LO 0
`define FILE_ADDR_HI 6
`define DEST_BIT 7
`define BIT_SEL_LO 7
`define BIT_SEL_HI 9
`define BITOP_LO 10
`define BITOP_HI 11
`define JUMP_KIND_BIT 11
`define STORE_PHASE 2'd2
`define CLASS_LO 12
`define CLASS_HI 13
`define PTR_NUM_BIT 2
`define MODE_LO 0
`define MODE_HI 1
`define CLASS_BYTE 2'b00
`define CLASS_BIT 2'b01
`define CLASS_JUMP 2'b10
`define CLASS_LIT 2'b11
`define BITOP_CLEAR 2'b00
`define BITOP_SET 2'b01
`define BITOP_SKIPC 2'b10
`define BITOP_SKIPS 2'b11
`define OP_DECREMENT_SKIP_IF_ZERO 14'h0b00
`define OP_INCFSZ 14'h0f00
`define BYTE_OP_MASK 14'h3f00
`define OP_CALL_ACCUMULATOR_RELATIVE 14'h000a
`define OP_BRW 14'h000b
`define OP_RETURN 14'h0008
`define OP_RETI 14'h0009
`define OP_RETLIT 14'h3400
`define RETLIT_MASK 14'h3c00
`define OP_BRA 14'h3200
`define BRA_MASK 14'h3e00
`define OP_MOVWI_MASK 14'h3ff8
`define OP_MOVIW 14'h0010
`define OP_MOVWI 14'h0018
`define SLOT0_ADDR 7'h00
`define SLOT1_ADDR 7'h01
`define ZERO_BYTE 8'h00

`endif

/* rtl/core_decode_pkg.sv */
// Purpose: types shared by the instruction decoder
// Assumes: nothing beyond the constants header
// Notes: none
package core_decode_pkg;
    typedef enum logic [1:0] {
        cls_byte,
        cls_bit,
        cls_literal_control
    } instr_class_t;

    typedef enum logic [1:0] {
        mode_pre_inc,
        mode_pre_dec,
        mode_post_inc,
        mode_post_dec
    } pointer_update_mode_t;
endpackage

/* test/decode_monitor.sv */
// Purpose: port-level timing checks for the decoder
// Assumes: one clock domain, synchronous reset high
// Notes: fields are judged only for words taken outside reset
`timescale 1ns/1ns
module decode_monitor
    import core_decode_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic [13:0] instr_word, // fetched word
    input instr_class_t instr_class, // class
    input wire logic [6:0] file_addr, // file address
    input wire logic [2:0] bit_sel, // bit position
    input wire logic dest_file, // destination
    input wire logic file_read, // read strobe
    input wire logic file_write, // file write strobe
    input wire logic acc_write, // accumulator write strobe
    input wire logic flow_change, // flow change
    input wire logic [1:0] phase, // phase
    input wire logic cycle_start, // cycle start
    input wire logic instr_start, // new instruction
    input wire logic nop_cycle // no-op cycle
);
    logic taken;
    logic [13:0] taken_word;
    // a private copy of the taken word keeps the field checks off $past
    always_ff @(posedge mclk) begin
        taken <= instr_start && !rst;
        if (instr_start) begin
            taken_word <= instr_word;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    phase_step_a: assert property (phase != 2'd3 |=> phase == $past(phase) + 2'd1)
        else $error("phase did not advance");
    cycle_len_a: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
        else $error("instruction cycle not four clocks");
    read_phase_a: assert property (file_read |-> phase == 2'd1 ##1 !file_read)
        else $error("read strobe misplaced");
    write_after_read_a: assert property ((file_write || acc_write) |-> $past(file_read, 2) && phase == 2'd3)
        else $error("write without earlier read");
    dest_sel_a: assert property ((file_write || acc_write) |-> file_write == dest_file && acc_write != dest_file)
        else $error("write went to wrong destination");
    flow_nop_a: assert property (flow_change && phase == 2'd3 && !nop_cycle |=> nop_cycle [*4])
        else $error("flow change without no-op cycle");
    nop_hold_a: assert property (nop_cycle |-> !instr_start)
        else $error("new instruction during no-op");
    addr_field_a: assert property (taken && !taken_word[13] |-> file_addr == taken_word[6:0])
        else $error("file address field wrong");
    bit_field_a: assert property (taken && taken_word[13:12] == 2'b01 |-> instr_class == cls_bit && bit_sel == taken_word[9:7])
        else $error("bit class or field wrong");
    reset_fresh_a: assert property (disable iff (1'b0) rst |=> phase == 2'd0 && !nop_cycle)
        else $error("reset left state pending");
endmodule

/* test/prog_mem_model.sv */
// Purpose: program memory side that offers one word per instruction
// Assumes: the word is taken on the edge where instr_start is high
// Notes: outside a fetch the bus shows the inverse of the last word
`timescale 1ns/1ns
module prog_mem_model (
    input wire logic mclk, // clock
    input wire logic instr_start, // decoder takes a word
    input wire logic [13:0] next_word, // word queued by the bench
    output logic [13:0] instr_word // word bus
);
    logic [13:0] last_word = 14'h0000;
    always_ff @(posedge mclk) begin
        if (instr_start) begin
            last_word <= next_word;
        end
    end
    // a stale sample by the decoder sees garbage, not the old word
    assign instr_word = instr_start ? next_word : ~last_word;
endmodule

/* test/tb.sv */
// Purpose: self-checking bench for the instruction decoder
// Assumes: inputs change on the falling edge
// Notes: cycle counts are measured between instruction starts
`timescale 1ns/1ns
module tb;
    import core_decode_pkg::*;
    logic mclk, rst, skip_taken, pointer0_msb, pointer1_msb;
    logic [13:0] next_word, instr_word;
    instr_class_t instr_class;
    pointer_update_mode_t pointer_update_mode;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic [1:0] bit_op, phase;
    logic [7:0] literal;
    logic dest_file, pointer_num, file_read, file_write, acc_write;
    logic flow_change, cycle_start, instr_start, nop_cycle;
    int bad_count = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h7309;
    logic [13:0] w;
    // bit 15 skip outcome, bit 14 both pointer top bits, rest the word
    logic [15:0] corner [21] = '{16'h9c85, 16'h1c85, 16'h9885, 16'h9485,
        16'h5000, 16'hcb01, 16'h8f85, 16'h000a, 16'h000b, 16'h0008,
        16'h0009, 16'h3455, 16'h3201, 16'h2800, 16'h2000, 16'h0100,
        16'h0103, 16'h4010, 16'h4015, 16'h401f, 16'h0016};
    core_instruction_decode_timing uut (.mclk(mclk), .rst(rst),
        .instr_word(instr_word), .skip_taken(skip_taken),
        .pointer0_msb(pointer0_msb), .pointer1_msb(pointer1_msb),
        .instr_class(instr_class), .file_addr(file_addr),
        .bit_sel(bit_sel), .bit_op(bit_op), .dest_file(dest_file),
        .literal(literal), .pointer_num(pointer_num),
        .pointer_update_mode(pointer_update_mode), .file_read(file_read),
        .file_write(file_write), .acc_write(acc_write),
        .flow_change(flow_change), .phase(phase),
        .cycle_start(cycle_start), .instr_start(instr_start),
        .nop_cycle(nop_cycle));
    prog_mem_model mem (.mclk(mclk), .instr_start(instr_start),
        .next_word(next_word), .instr_word(instr_word));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic int exp_cyc(logic [13:0] v, logic s, p0, p1);
        int n;
        n = 1;
        if (v[13:12] == 2'b01 && v[11] && s) n = 2;
        if (v[13:12] == 2'b00 && v[11] && v[9:8] == 2'b11 && s) n = 2;
        if (v[13:12] == 2'b10) n = 2;
        if (v[13:12] == 2'b11 && (v[11:10] == 2'b01 || v[11:9] == 3'b001))
            n = 2;
        if (v[13:4] == 10'h000 && v[3:2] == 2'b10) n = 2;
        // pointer aimed at program memory costs a cycle
        if (!v[13] && v[6:1] == 6'h00 && (v[0] ? p1 : p0)) n++;
        if (v[13:5] == 9'h000 && v[4] && (v[2] ? p1 : p0)) n++;
        return n;
    endfunction
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_start(output int n);
        n = 0;
        while (instr_start !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20) begin
            bad_count++;
            end_of_test();
        end
    endtask
    task automatic run(logic [13:0] v, logic s, p0, p1);
        int n;
        wait_start(n);
        next_word = v;
        skip_taken = s;
        pointer0_msb = p0;
        pointer1_msb = p1;
        @(negedge mclk);
        if (!v[13] && v[13:8] != 6'h00) begin
            chk("file_addr", 16'(file_addr), 16'(v[6:0]));
            chk("dest_file", 16'(dest_file), 16'(v[12] | v[7]));
        end
        chk("class", 16'(instr_class), 16'(v[13] ? 2 : v[12]));
        if (v[13:12] == 2'b01)
            chk("bit_op", 16'(bit_op), 16'(v[11:10]));
        if (v[13:12] == 2'b11)
            chk("literal", 16'(literal), 16'(v[7:0]));
        chk("flow_change", 16'(flow_change),
            16'(exp_cyc(v, 1'b0, 1'b0, 1'b0) > 1));
        if (v[13:5] == 9'h000 && v[4]) begin
            chk("mode", 16'(pointer_update_mode), 16'(v[1:0]));
            chk("pointer_num", 16'(pointer_num), 16'(v[2]));
        end
        wait_start(n);
        chk("cycles", 16'(n + 1), 16'(4 * exp_cyc(v, s, p0, p1)));
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        chk("phase", 16'(phase), 16'h0000);
        chk("instr_start", 16'(instr_start), 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {skip_taken, pointer0_msb, pointer1_msb} = 3'h0;
        next_word = 14'h0000;
        do_reset();
        foreach (corner[i]) begin
            run(corner[i][13:0], corner[i][15], corner[i][14], corner[i][14]);
        end
        do_reset();
        repeat (40) begin
            seed = lfsr(seed);
            w = seed[13:0];
            // keep off the 0x00xx control forms and class-3 slot aliases
            if (w[13:12] == 2'b00) w[9] = 1'b1;
            if (w[13]) w[1] = 1'b1;
            run(w, seed[20], seed[25], seed[30]);
        end
        end_of_test();
    end
endmodule
bind core_instruction_decode_timing decode_monitor mon (.mclk(mclk),
    .rst(rst), .instr_word(instr_word), .instr_class(instr_class),
    .file_addr(file_addr), .bit_sel(bit_sel), .dest_file(dest_file),
    .file_read(file_read), .file_write(file_write), .acc_write(acc_write),
    .flow_change(flow_change), .phase(phase), .cycle_start(cycle_start),
    .instr_start(instr_start), .nop_cycle(nop_cycle));
